// *** lq_pkg.sv ***
// Purpose: Shared types and constants for the link quality sequencer
// Assumes: One clock domain, Avalon-MM register access
// Notes: Sequence number is polarity in bit 7, count in bits 6..0
package lq_pkg;
  localparam int LQ_PAY_W = 16;
  localparam int LQ_POL = 7;
  localparam logic [6:0] LQ_CNT_RST = 7'h00;
  localparam logic [7:0] LQ_MAX_PEND = 8'h80;
  localparam logic [15:0] LQ_RETRY_RST = 16'h0000;
  localparam logic [4:0] LQ_A_CTRL = 5'h00;
  localparam logic [4:0] LQ_A_STAT = 5'h04;
  localparam logic [4:0] LQ_A_SEQ = 5'h08;
  localparam logic [4:0] LQ_A_RETR = 5'h0C;
  localparam logic [4:0] LQ_A_FILL = 5'h10;
  localparam int LQ_C_COLD = 0;
  localparam int LQ_C_WARM = 1;
  localparam int LQ_C_IDLE = 2;

  typedef enum logic [3:0] {
    LQ_W_NONE = 4'h0,
    LQ_W_END_DATA = 4'h1,
    LQ_W_END_BCAST = 4'h2,
    LQ_W_CREDIT = 4'h3,
    LQ_W_START_IDLE = 4'h4,
    LQ_W_FULL = 4'h5,
    LQ_W_ACK = 4'h6,
    LQ_W_NACK = 4'h7,
    LQ_W_RETRY = 4'h8
  } lq_wtype_t;

  typedef enum logic [1:0] {
    LQ_K_DATA = 2'b00,
    LQ_K_CREDIT = 2'b01,
    LQ_K_BCAST = 2'b10
  } lq_kind_t;

  typedef enum logic [1:0] {
    LQ_VALID_POS = 2'b00,
    LQ_ERR_NEG = 2'b01,
    LQ_VALID_NEG = 2'b10,
    LQ_ERR_POS = 2'b11
  } lq_rxerr_t;

  typedef struct packed {
    logic valid;
    lq_kind_t kind;
    logic [LQ_PAY_W-1:0] payload;
  } lq_frame_in_t;

  typedef struct packed {
    logic valid;
    lq_wtype_t wtype;
    logic late;
    logic [7:0] seqn;
    logic [LQ_PAY_W-1:0] payload;
  } lq_word_out_t;

  typedef struct packed {
    logic valid;
    lq_wtype_t wtype;
    logic crc_ok;
    logic [7:0] seqn;
  } lq_word_in_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } lq_avs_req_t;
endpackage

// *** lq_seq_retry.sv ***
// Purpose: Sequence numbering, sequence checking and retry buffering
// Assumes: Framing, lane and CRC logic sit on the same clock
// Notes: One retry buffer for data and credit words, one for broadcasts
//
// Notes on behaviour
// - Seven-bit transmit counter, wraps at 128.
// - Cold reset, flush clear; warm keeps transmit state.
// - Transmit polarity flips when a retry starts.
// - Frame end words take incremented count.
// - Idle and full words carry current count.
// - Seven-bit receive counter with polarity flag.
// - Cold reset, flush clear; warm keeps receive count.
// - Receive polarity comes from error state machine.
// - Good-check incoming words get sequence compare.
// - Frames accepted only at counter plus one.
// - Idle and full words must match exactly.
// - Sent frames kept, indexed by their number.
// - Acknowledge deletes entries up to its count.
// - Wrong-polarity negative acknowledge ignored; else resend.
// - Resent frames renumbered from acknowledged plus one.
// - Broadcasts resent ahead of data and credit.
// - Retry count readable; any reset clears it.
// - Cold reset, flush empty buffers; warm keeps.
// - Full buffer refuses framing input, sends full.
// - 128 outstanding frames forces full words.
// - All buffers full: full words, alternating with any unsent frames.
// - Late flag set only on resent broadcasts.
// - Error machine to valid-positive on resets.
// - Negative acknowledge carries inverted receive polarity.
//
// The implementer's own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module lq_seq_retry import lq_pkg::*; #(
  parameter int DAW = 6,
  parameter int BAW = 3
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic flush_i,
  input wire lq_frame_in_t frame_i,
  output logic data_ready_o,
  output logic bcast_ready_o,
  output lq_word_out_t word_o,
  input wire logic lane_ready_i,
  input wire lq_word_in_t rx_i,
  output logic rx_accept_o,
  output logic rx_reject_o,
  output logic ack_req_o,
  output logic nack_req_o,
  output logic [7:0] ack_seq_o,
  output logic [7:0] nack_seq_o,
  input wire lq_avs_req_t avs_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);
  typedef struct packed {
    logic [6:0] tx_cnt;
    logic tx_pol;
    logic [6:0] rx_cnt;
    lq_rxerr_t rxerr;
    logic [6:0] base;
    logic [6:0] ack_to;
    logic [7:0] pending;
    logic retry_pend;
    logic [DAW:0] d_head;
    logic [DAW:0] d_sp;
    logic [DAW:0] d_tail;
    logic [BAW:0] b_head;
    logic [BAW:0] b_sp;
    logic [BAW:0] b_tail;
    logic [15:0] retries;
    logic idle_req;
    logic full_turn;
    lq_word_out_t word;
    logic data_rdy;
    logic bc_rdy;
    logic rx_acc;
    logic rx_rej;
    logic ack_rq;
    logic nack_rq;
    logic [7:0] ack_seq;
    logic [7:0] nack_seq;
    logic waitreq;
    logic [31:0] rdata;
  } lq_state_t;

  function automatic logic [6:0] inc7(input logic [6:0] a);
    return a + 7'h01;
  endfunction

  function automatic logic pol_of(input lq_rxerr_t e);
    return (e == LQ_ERR_NEG) || (e == LQ_VALID_NEG);
  endfunction

  function automatic logic is_frame(input lq_wtype_t t);
    return (t == LQ_W_END_DATA) || (t == LQ_W_END_BCAST) ||
      (t == LQ_W_CREDIT);
  endfunction

  lq_state_t st;
  lq_state_t n;

  // Payload plus credit flag; sequence and sent mark kept apart
  logic [LQ_PAY_W:0] d_mem [2**DAW];
  logic [6:0] d_seqm [2**DAW];
  logic d_sent [2**DAW];
  logic [LQ_PAY_W-1:0] b_mem [2**BAW];
  logic [6:0] b_seqm [2**BAW];
  logic b_sent [2**BAW];

  logic d_we;
  logic b_we;
  logic d_tx;
  logic b_tx;
  logic d_pop;
  logic b_pop;
  logic sif_go;
  logic slot;
  logic win_ok;
  logic cold_go;
  logic warm_go;
  logic ctl_wr;
  logic rx_pol;
  logic [DAW:0] d_occ;
  logic [BAW:0] b_occ;
  logic d_full;
  logic b_full;
  logic [6:0] ack_dist;
  logic [DAW:0] nd_occ;
  logic [BAW:0] nb_occ;

  assign ctl_wr = avs_i.write && !st.waitreq &&
    avs_i.address == LQ_A_CTRL && avs_i.byteenable[0];
  assign cold_go = flush_i || (ctl_wr && avs_i.writedata[LQ_C_COLD]);
  assign warm_go = ctl_wr && avs_i.writedata[LQ_C_WARM];
  assign rx_pol = pol_of(st.rxerr);
  assign d_occ = st.d_tail - st.d_head;
  assign b_occ = st.b_tail - st.b_head;
  assign d_full = d_occ[DAW];
  assign b_full = b_occ[BAW];
  assign slot = !st.word.valid || lane_ready_i;
  // Oldest outstanding count sits at base plus one
  assign ack_dist = rx_i.seqn[6:0] - st.base;
  assign win_ok = ({1'b0, ack_dist} <= st.pending) &&
    (ack_dist >= (st.ack_to - st.base)) && !st.retry_pend;

  always_comb begin
    n = st;
    d_we = 1'b0;
    b_we = 1'b0;
    d_tx = 1'b0;
    b_tx = 1'b0;
    d_pop = 1'b0;
    b_pop = 1'b0;
    sif_go = 1'b0;
    n.rx_acc = 1'b0;
    n.rx_rej = 1'b0;
    n.ack_rq = 1'b0;
    n.nack_rq = 1'b0;
    n.waitreq = !((avs_i.read || avs_i.write) && st.waitreq);
    if (avs_i.read && st.waitreq) begin
      case (avs_i.address)
        LQ_A_STAT: n.rdata = {24'h000000, st.rxerr, st.retry_pend,
          rx_pol, st.tx_pol, d_full & b_full, d_full, b_full};
        LQ_A_SEQ: n.rdata = {1'b0, st.ack_to, 1'b0, st.base,
          rx_pol, st.rx_cnt, st.tx_pol, st.tx_cnt};
        LQ_A_RETR: n.rdata = {16'h0000, st.retries};
        LQ_A_FILL: n.rdata = {8'h00, 4'(b_occ), 12'(d_occ), st.pending};
        default: n.rdata = 32'h00000000;
      endcase
    end
    if (st.word.valid && lane_ready_i) begin
      n.word.valid = 1'b0;
    end
    if (cold_go) begin
      n.tx_cnt = LQ_CNT_RST;
      n.tx_pol = 1'b0;
      n.rx_cnt = LQ_CNT_RST;
      n.rxerr = LQ_VALID_POS;
      n.base = LQ_CNT_RST;
      n.ack_to = LQ_CNT_RST;
      n.pending = 8'h00;
      n.retry_pend = 1'b0;
      n.d_head = '0;
      n.d_sp = '0;
      n.d_tail = '0;
      n.b_head = '0;
      n.b_sp = '0;
      n.b_tail = '0;
      n.retries = LQ_RETRY_RST;
      n.idle_req = 1'b0;
      n.word.valid = 1'b0;
    end else if (warm_go) begin
      // Counters and buffers survive, only these restart
      n.rxerr = LQ_VALID_POS;
      n.retries = LQ_RETRY_RST;
    end else begin
      if (ctl_wr && avs_i.writedata[LQ_C_IDLE]) begin
        n.idle_req = 1'b1;
      end
      if (frame_i.valid && frame_i.kind != LQ_K_BCAST && st.data_rdy) begin
        d_we = 1'b1;
        n.d_tail = st.d_tail + 1'b1;
      end
      if (frame_i.valid && frame_i.kind == LQ_K_BCAST && st.bc_rdy) begin
        b_we = 1'b1;
        n.b_tail = st.b_tail + 1'b1;
      end
      if (rx_i.valid && rx_i.crc_ok) begin
        if (is_frame(rx_i.wtype)) begin
          if (rx_i.seqn == {rx_pol, inc7(st.rx_cnt)}) begin
            n.rx_cnt = inc7(st.rx_cnt);
            n.rx_acc = 1'b1;
            n.ack_rq = 1'b1;
          end else begin
            n.rx_rej = 1'b1;
            n.nack_rq = 1'b1;
          end
        end else if (rx_i.wtype == LQ_W_START_IDLE ||
            rx_i.wtype == LQ_W_FULL) begin
          if (rx_i.seqn == {rx_pol, st.rx_cnt}) begin
            n.ack_rq = rx_i.wtype == LQ_W_FULL;
          end else begin
            n.rx_rej = 1'b1;
            n.nack_rq = 1'b1;
          end
        end else if (rx_i.seqn[LQ_POL] == st.tx_pol && win_ok) begin
          if (rx_i.wtype == LQ_W_ACK) begin
            n.ack_to = rx_i.seqn[6:0];
          end else if (rx_i.wtype == LQ_W_NACK) begin
            n.ack_to = rx_i.seqn[6:0];
            n.tx_pol = !st.tx_pol;
            n.retry_pend = 1'b1;
            n.retries = st.retries + 16'h0001;
          end
        end
      end
      // A nack moves a valid state to error, an ack moves an error state on to valid
      case (st.rxerr)
        LQ_VALID_POS: if (n.nack_rq) n.rxerr = LQ_ERR_NEG;
        LQ_ERR_NEG: if (n.ack_rq) n.rxerr = LQ_VALID_NEG;
        LQ_VALID_NEG: if (n.nack_rq) n.rxerr = LQ_ERR_POS;
        LQ_ERR_POS: if (n.ack_rq) n.rxerr = LQ_VALID_POS;
        default: n.rxerr = LQ_VALID_POS;
      endcase
      // Sent numbers are consecutive, so one pop per cycle suffices
      if (st.base != st.ack_to) begin
        if (st.d_head != st.d_sp &&
            d_seqm[st.d_head[DAW-1:0]] == inc7(st.base)) begin
          d_pop = 1'b1;
          n.d_head = st.d_head + 1'b1;
        end else if (st.b_head != st.b_sp &&
            b_seqm[st.b_head[BAW-1:0]] == inc7(st.base)) begin
          b_pop = 1'b1;
          n.b_head = st.b_head + 1'b1;
        end
        n.base = (d_pop || b_pop) ? inc7(st.base) : st.ack_to;
        n.pending = (d_pop || b_pop) ? st.pending - 8'h01 : st.pending;
      end
      if (slot) begin
        n.full_turn = 1'b1;
        if (st.retry_pend) begin
          if (st.base == st.ack_to) begin
            n.word = '{1'b1, LQ_W_RETRY, 1'b0, {st.tx_pol, st.base},
              '0};
            n.tx_cnt = st.base;
            n.pending = 8'h00;
            n.d_sp = st.d_head;
            n.b_sp = st.b_head;
            n.retry_pend = 1'b0;
          end
        end else if (((d_full && b_full) || st.pending >= LQ_MAX_PEND) &&
            !(st.pending < LQ_MAX_PEND &&
              (st.d_sp != st.d_tail || st.b_sp != st.b_tail)) ||
            ((d_full || b_full) && st.full_turn)) begin
          // One full buffer alternates full words with traffic
          n.word = '{1'b1, LQ_W_FULL, 1'b0, {st.tx_pol, st.tx_cnt},
            '0};
          n.full_turn = 1'b0;
        end else if (st.pending < LQ_MAX_PEND && st.b_sp != st.b_tail) begin
          b_tx = 1'b1;
          n.word = '{1'b1, LQ_W_END_BCAST, b_sent[st.b_sp[BAW-1:0]],
            {st.tx_pol, inc7(st.tx_cnt)}, b_mem[st.b_sp[BAW-1:0]]};
          n.tx_cnt = inc7(st.tx_cnt);
          n.b_sp = st.b_sp + 1'b1;
          n.pending = n.pending + 8'h01;
        end else if (st.pending < LQ_MAX_PEND && st.d_sp != st.d_tail) begin
          d_tx = 1'b1;
          n.word = '{1'b1, d_mem[st.d_sp[DAW-1:0]][LQ_PAY_W] ?
            LQ_W_CREDIT : LQ_W_END_DATA, 1'b0,
            {st.tx_pol, inc7(st.tx_cnt)},
            d_mem[st.d_sp[DAW-1:0]][LQ_PAY_W-1:0]};
          n.tx_cnt = inc7(st.tx_cnt);
          n.d_sp = st.d_sp + 1'b1;
          n.pending = n.pending + 8'h01;
        end else if (st.idle_req) begin
          sif_go = 1'b1;
          n.word = '{1'b1, LQ_W_START_IDLE, 1'b0,
            {st.tx_pol, st.tx_cnt}, '0};
          // A request written in this very cycle must not be lost
          n.idle_req = ctl_wr && avs_i.writedata[LQ_C_IDLE];
        end
      end
    end
    n.ack_seq = {pol_of(n.rxerr), n.rx_cnt};
    n.nack_seq = {!pol_of(n.rxerr), n.rx_cnt};
    nd_occ = n.d_tail - n.d_head;
    nb_occ = n.b_tail - n.b_head;
    n.data_rdy = !nd_occ[DAW];
    n.bc_rdy = !nb_occ[BAW];
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
      st.waitreq <= 1'b1;
      st.data_rdy <= 1'b1;
      st.bc_rdy <= 1'b1;
    end else begin
      st <= n;
    end
  end

  // No reset on storage; pointers alone define what is valid
  always_ff @(posedge clk_i) begin
    if (d_we) begin
      d_mem[st.d_tail[DAW-1:0]] <= {frame_i.kind == LQ_K_CREDIT,
        frame_i.payload};
      d_sent[st.d_tail[DAW-1:0]] <= 1'b0;
    end
    if (d_tx) begin
      d_seqm[st.d_sp[DAW-1:0]] <= inc7(st.tx_cnt);
      d_sent[st.d_sp[DAW-1:0]] <= 1'b1;
    end
    if (b_we) begin
      b_mem[st.b_tail[BAW-1:0]] <= frame_i.payload;
      b_sent[st.b_tail[BAW-1:0]] <= 1'b0;
    end
    if (b_tx) begin
      b_seqm[st.b_sp[BAW-1:0]] <= inc7(st.tx_cnt);
      b_sent[st.b_sp[BAW-1:0]] <= 1'b1;
    end
  end

  assign data_ready_o = st.data_rdy;
  assign bcast_ready_o = st.bc_rdy;
  assign word_o = st.word;
  assign rx_accept_o = st.rx_acc;
  assign rx_reject_o = st.rx_rej;
  assign ack_req_o = st.ack_rq;
  assign nack_req_o = st.nack_rq;
  assign ack_seq_o = st.ack_seq;
  assign nack_seq_o = st.nack_seq;
  assign avs_readdata_o = st.rdata;
  assign avs_waitrequest_o = st.waitreq;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_quiet;
    !cold_go && !warm_go;
  endsequence
  sequence s_nack_ok;
    (rx_i.valid && rx_i.crc_ok && rx_i.wtype == LQ_W_NACK &&
      rx_i.seqn[LQ_POL] == st.tx_pol && win_ok) and s_quiet;
  endsequence
  sequence s_retry_go;
    (st.retry_pend && st.base == st.ack_to && slot) and s_quiet;
  endsequence
  sequence s_rx_frame;
    (rx_i.valid && rx_i.crc_ok && is_frame(rx_i.wtype)) and s_quiet;
  endsequence

  a_nack_flips_pol: assert property (
    s_nack_ok |=> st.tx_pol != $past(st.tx_pol) && st.retry_pend)
    else $error("accepted nack did not start a retry");
  a_nack_wrong_pol: assert property (
    (rx_i.valid && rx_i.wtype == LQ_W_NACK &&
    rx_i.seqn[LQ_POL] != st.tx_pol && !st.retry_pend) and s_quiet
    |=> $stable(st.tx_pol) && !st.retry_pend)
    else $error("nack of wrong polarity acted on");
  a_retry_renum: assert property (
    s_retry_go |=> st.tx_cnt == $past(st.ack_to) &&
    word_o.wtype == LQ_W_RETRY ##1 (!word_o.valid ||
    word_o.wtype != LQ_W_RETRY || $stable(st.tx_cnt)))
    else $error("retry did not renumber from nack count");
  a_frame_number: assert property (
    (d_tx || b_tx) |=> word_o.seqn == {$past(st.tx_pol),
    inc7($past(st.tx_cnt))} && st.tx_cnt == word_o.seqn[6:0])
    else $error("frame end word number wrong");
  a_idle_number: assert property (
    sif_go |=> word_o.wtype == LQ_W_START_IDLE &&
    word_o.seqn == {$past(st.tx_pol), $past(st.tx_cnt)} &&
    $stable(st.tx_cnt))
    else $error("idle word number wrong");
  a_cold_clear: assert property (
    cold_go |=> st.tx_cnt == 7'h00 && !st.tx_pol && st.rx_cnt == 7'h00 &&
    st.retries == 16'h0000 && st.d_head == st.d_tail &&
    st.b_head == st.b_tail)
    else $error("cold reset left state behind");
  a_warm_keep: assert property (
    warm_go && !cold_go |=> $stable(st.tx_cnt) && $stable(st.rx_cnt) &&
    $stable(st.d_tail) && st.retries == 16'h0000 &&
    st.rxerr == LQ_VALID_POS)
    else $error("warm reset effect wrong");
  a_rx_in_order: assert property (
    s_rx_frame ##0 (rx_i.seqn == {rx_pol, inc7(st.rx_cnt)})
    |=> rx_accept_o && ack_req_o && st.rx_cnt == inc7($past(st.rx_cnt)))
    else $error("in-order frame not accepted");
  a_rx_out_order: assert property (
    s_rx_frame ##0 (rx_i.seqn != {rx_pol, inc7(st.rx_cnt)})
    |=> rx_reject_o && nack_req_o && $stable(st.rx_cnt))
    else $error("out-of-order frame not rejected");
  a_idle_mismatch: assert property (
    (rx_i.valid && rx_i.crc_ok && rx_i.wtype == LQ_W_START_IDLE &&
    rx_i.seqn != {rx_pol, st.rx_cnt}) and s_quiet
    |=> nack_req_o && !ack_req_o ##1 !nack_req_o || rx_i.valid)
    else $error("idle mismatch did not request nack");
  a_full_refuse: assert property (
    d_full && frame_i.valid && frame_i.kind == LQ_K_DATA
    |=> $stable(st.d_tail))
    else $error("data taken into full buffer");
  a_late_flag: assert property (
    word_o.valid && word_o.wtype != LQ_W_END_BCAST |-> !word_o.late)
    else $error("late flag on non-broadcast word");
  a_nack_polarity: assert property (
    nack_req_o |-> nack_seq_o[LQ_POL] != ack_seq_o[LQ_POL] &&
    nack_seq_o[LQ_POL] == !pol_of(st.rxerr))
    else $error("nack polarity not inverted");
endmodule
`default_nettype wire

// *** lq_far_model.sv ***
// Purpose: Far-end lane consumer taking words from the sequencer
// Assumes: Same clock as the sequencer, each word held until taken
// Notes: Slow mode takes a word only every other cycle, to stall the sender
`timescale 1ns/1ps
`default_nettype none
module lq_far_model import lq_pkg::*; (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic slow_i,
  input wire lq_word_out_t word_i,
  output logic lane_ready_o
);
  lq_word_out_t taken[$];
  logic [7:0] last_seq [16];
  int n_seen [16];
  logic phase;
  initial begin
    lane_ready_o = 1'b0;
    phase = 1'b0;
  end
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      lane_ready_o <= 1'b0;
    end else begin
      phase <= ~phase;
      lane_ready_o <= slow_i ? phase : 1'b1;
      if (word_i.valid && lane_ready_o) begin
        taken.push_back(word_i);
        last_seq[word_i.wtype] <= word_i.seqn;
        n_seen[word_i.wtype] <= n_seen[word_i.wtype] + 1;
      end
    end
  end
endmodule
`default_nettype wire

// *** test_link_sequence_retry_control.sv ***
// Purpose: Self-checking bench for the link quality sequencer
// Assumes: Avalon-MM access ends when waitrequest is seen low
// Notes: Fill and wrap runs use the design's default buffer depths
`timescale 1ns/1ps
`default_nettype none
module test_link_sequence_retry_control import lq_pkg::*;;
  logic clk_i, sys_rst_i, flush_i, lane_ready_i, slow;
  lq_frame_in_t frame_i;
  lq_word_out_t word_o;
  lq_word_in_t rx_i;
  lq_avs_req_t avs_i;
  logic data_ready_o, bcast_ready_o, rx_accept_o, rx_reject_o;
  logic ack_req_o, nack_req_o, avs_waitrequest_o;
  logic [7:0] ack_seq_o, nack_seq_o;
  logic [31:0] avs_readdata_o, rd;
  int miscompares, n_checks, cycles;

  lq_seq_retry #(.DAW(6), .BAW(3)) u_lq_seq_retry (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .flush_i(flush_i),
    .frame_i(frame_i), .data_ready_o(data_ready_o),
    .bcast_ready_o(bcast_ready_o), .word_o(word_o),
    .lane_ready_i(lane_ready_i), .rx_i(rx_i), .rx_accept_o(rx_accept_o),
    .rx_reject_o(rx_reject_o), .ack_req_o(ack_req_o),
    .nack_req_o(nack_req_o), .ack_seq_o(ack_seq_o),
    .nack_seq_o(nack_seq_o), .avs_i(avs_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o));

  lq_far_model u_lq_far_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .slow_i(slow), .word_i(word_o), .lane_ready_o(lane_ready_i));

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Request held until the edge that sees waitrequest low
  task automatic avs(input logic wr, input logic [4:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    avs_i <= '{read: ~wr, write: wr, address: a, byteenable: 4'hF,
               writedata: wd};
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0) begin
      @(posedge clk_i);
      n++;
    end
    rd = avs_readdata_o;
    avs_i <= '0;
    check("bus wait states", n, 32'h1);
    // Idle edge keeps the next request off this time step
    @(posedge clk_i);
  endtask

  task automatic rd_chk(input string nm, input logic [4:0] a,
                        input logic [31:0] m, input logic [31:0] e);
    avs(1'b0, a, 32'h0);
    check(nm, rd & m, e);
  endtask

  task automatic push(input lq_kind_t k);
    int n;
    n = 0;
    frame_i <= '{valid: 1'b1, kind: k, payload: 16'hA5C3};
    @(posedge clk_i);
    while (((k == LQ_K_BCAST) ? bcast_ready_o : data_ready_o) !== 1'b1
           && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    frame_i <= '0;
    @(posedge clk_i);
  endtask

  task automatic rx_send(input lq_wtype_t t, input logic ok,
                         input logic [7:0] s, input logic ea,
                         input logic er);
    rx_i <= '{valid: 1'b1, wtype: t, crc_ok: ok, seqn: s};
    @(posedge clk_i);
    rx_i <= '0;
    @(posedge clk_i);
    check("rx accept", rx_accept_o, ea);
    check("rx reject", rx_reject_o, er);
  endtask

  task automatic expect_word(input lq_wtype_t t, input logic [7:0] s,
                             input logic lt, input logic cs);
    lq_word_out_t w;
    int n;
    n = 0;
    w = '0;
    while (u_lq_far_model.taken.size() == 0 && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    if (u_lq_far_model.taken.size() != 0) begin
      w = u_lq_far_model.taken.pop_front();
    end
    check("word type", w.wtype, t);
    if (cs) check("word seqn", w.seqn, s);
    check("word late", w.late, lt);
  endtask

  // Clearing off the rising edge keeps clear of the model's own pushes
  task automatic clr_q();
    @(negedge clk_i);
    u_lq_far_model.taken.delete();
    @(posedge clk_i);
  endtask

  task automatic t_reset_regs();
    check("data ready", data_ready_o, 32'h1);
    check("bcast ready", bcast_ready_o, 32'h1);
    rd_chk("seq", LQ_A_SEQ, 32'h0000FFFF, 32'h0);
    rd_chk("fill", LQ_A_FILL, 32'h00FFFFFF, 32'h0);
    rd_chk("retries", LQ_A_RETR, 32'hFFFF, {16'h0, LQ_RETRY_RST});
    avs(1'b1, LQ_A_SEQ, 32'hFFFFFFFF);
    rd_chk("seq ro", LQ_A_SEQ, 32'h0000FFFF, 32'h0);
    avs(1'b1, 5'h14, 32'hFFFFFFFF);
    rd_chk("unmapped", 5'h14, 32'hFFFFFFFF, 32'h0);
  endtask

  task automatic t_tx_numbering();
    push(LQ_K_DATA);
    push(LQ_K_CREDIT);
    push(LQ_K_BCAST);
    expect_word(LQ_W_END_DATA, 8'h01, 1'b0, 1'b1);
    expect_word(LQ_W_CREDIT, 8'h02, 1'b0, 1'b1);
    expect_word(LQ_W_END_BCAST, 8'h03, 1'b0, 1'b1);
    rd_chk("pending", LQ_A_FILL, 32'hFF, 32'h3);
    avs(1'b1, LQ_A_CTRL, 32'h4);
    expect_word(LQ_W_START_IDLE, 8'h03, 1'b0, 1'b1);
    clr_q();
  endtask

  task automatic t_rx_checking();
    rx_send(LQ_W_END_DATA, 1'b1, 8'h01, 1'b1, 1'b0);
    check("ack req", ack_req_o, 32'h1);
    check("ack seq", ack_seq_o, 32'h01);
    check("nack seq", nack_seq_o, 32'h81);
    rx_send(LQ_W_END_DATA, 1'b1, 8'h01, 1'b0, 1'b1);
    rx_send(LQ_W_CREDIT, 1'b0, 8'h02, 1'b0, 1'b0);
    rx_send(LQ_W_END_BCAST, 1'b1, 8'h82, 1'b1, 1'b0);
    check("ack seq pol", ack_seq_o, 32'h82);
    rx_send(LQ_W_CREDIT, 1'b1, 8'h03, 1'b0, 1'b1);
    rx_send(LQ_W_START_IDLE, 1'b1, 8'h02, 1'b0, 1'b0);
    rx_send(LQ_W_START_IDLE, 1'b1, 8'h82, 1'b0, 1'b1);
    check("nack req", nack_req_o, 32'h1);
    rd_chk("rx count", LQ_A_SEQ, 32'h7F00, 32'h0200);
  endtask

  task automatic t_ack_nack();
    rx_send(LQ_W_ACK, 1'b1, 8'h01, 1'b0, 1'b0);
    repeat (8) @(posedge clk_i);
    rd_chk("pending ack", LQ_A_FILL, 32'hFF, 32'h2);
    rx_send(LQ_W_NACK, 1'b1, 8'h82, 1'b0, 1'b0);
    repeat (8) @(posedge clk_i);
    rd_chk("retries", LQ_A_RETR, 32'hFFFF, 32'h0);
    check("no resend", u_lq_far_model.taken.size(), 32'h0);
    rx_send(LQ_W_NACK, 1'b1, 8'h02, 1'b0, 1'b0);
    expect_word(LQ_W_RETRY, 8'h00, 1'b0, 1'b0);
    expect_word(LQ_W_END_BCAST, 8'h83, 1'b1, 1'b1);
    rd_chk("retries", LQ_A_RETR, 32'hFFFF, 32'h1);
    rd_chk("pending nack", LQ_A_FILL, 32'hFF, 32'h1);
  endtask

  task automatic t_resets();
    avs(1'b1, LQ_A_CTRL, 32'h2);
    rd_chk("warm retries", LQ_A_RETR, 32'hFFFF, 32'h0);
    rd_chk("warm tx", LQ_A_SEQ, 32'hFF, 32'h83);
    rd_chk("warm rx", LQ_A_SEQ, 32'h7F00, 32'h0200);
    rd_chk("warm fill", LQ_A_FILL, 32'hFF, 32'h1);
    avs(1'b1, LQ_A_CTRL, 32'h1);
    repeat (2) @(posedge clk_i);
    rd_chk("cold seq", LQ_A_SEQ, 32'hFFFF, 32'h0);
    rd_chk("cold fill", LQ_A_FILL, 32'h00FFFFFF, 32'h0);
    clr_q();
  endtask

  // Two full batches take the count to 128, wrapping it to zero, with the far end stalling
  task automatic t_fill_wrap();
    slow <= 1'b1;
    repeat (64) push(LQ_K_DATA);
    repeat (200) @(posedge clk_i);
    check("ready full", data_ready_o, 32'h0);
    check("last data", u_lq_far_model.last_seq[LQ_W_END_DATA], 32'h40);
    check("full seen", u_lq_far_model.n_seen[LQ_W_FULL] != 0, 32'h1);
    check("full seqn", u_lq_far_model.last_seq[LQ_W_FULL], 32'h40);
    rd_chk("pending", LQ_A_FILL, 32'hFF, 32'h40);
    rx_send(LQ_W_ACK, 1'b1, 8'h40, 1'b0, 1'b0);
    repeat (100) @(posedge clk_i);
    rd_chk("pending ack", LQ_A_FILL, 32'hFF, 32'h0);
    check("ready again", data_ready_o, 32'h1);
    repeat (64) push(LQ_K_DATA);
    repeat (200) @(posedge clk_i);
    check("wrap", u_lq_far_model.last_seq[LQ_W_END_DATA], 32'h00);
    slow <= 1'b0;
  endtask

  task automatic t_flush();
    flush_i <= 1'b1;
    @(posedge clk_i);
    flush_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check("flush ready", data_ready_o, 32'h1);
    rd_chk("flush seq", LQ_A_SEQ, 32'hFFFF, 32'h0);
    rd_chk("flush fill", LQ_A_FILL, 32'h00FFFFFF, 32'h0);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Whole run needs about a thousand cycles; the ceiling leaves ample room
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  initial begin
    sys_rst_i = 1'b1;
    flush_i = 1'b0;
    slow = 1'b0;
    frame_i = '0;
    rx_i = '0;
    avs_i = '0;
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset_regs();
    t_tx_numbering();
    t_rx_checking();
    t_ack_nack();
    t_resets();
    t_fill_wrap();
    t_flush();
    end_of_test();
  end
endmodule
`default_nettype wire
